// >>> src/flash_irq_defs.svh
// constants for the flash interrupt status block
`ifndef FLASH_IRQ_DEFS_SVH
`define FLASH_IRQ_DEFS_SVH
`define IRQ_REG_ADDR      16'hf241
`define IRQ_BIT_MASTER    15
`define IRQ_BIT_LOAD      7
`define IRQ_BIT_PROG      6
`define IRQ_BIT_ERASE     5
`define IRQ_BIT_RESET     4
`define IRQ_COLD_VALUE    16'h8080
`define IRQ_WARM_VALUE    16'h8010
`define IRQ_ZERO          16'h0000
`define CMD_LOAD_A        16'h0000
`define CMD_LOAD_B        16'h0013
`define CMD_PROG_A        16'h0080
`define CMD_PROG_B        16'h001a
`define CMD_PROG_C        16'h001b
`define CMD_ERASE_A       16'h0094
`define CMD_ERASE_B       16'h0095
`define CMD_ERASE_C       16'h0030
`define CMD_RST_A         16'h00b0
`define CMD_RST_B         16'h00f0
`define CMD_RST_C         16'h00f3
`define CMD_UNLOCK        16'h0023
`define CMD_LOCK          16'h002a
`define CMD_LOCKTIGHT     16'h002c
`define CMD_ERASE_VERIFY  16'h0071
`define CMD_OTP_ACCESS    16'h0065
`endif

// >>> src/flash_irq_pkg.sv
// types for the flash interrupt status block
package flash_irq_pkg;
    typedef enum logic [2:0] {
        EV_NONE,
        EV_LOAD,
        EV_PROG,
        EV_ERASE,
        EV_RESET,
        EV_MASTER
    } event_class_e;

    typedef struct packed {
        logic load_done_flag;
        logic program_done_flag;
        logic erase_done_flag;
        logic reset_done_flag;
    } done_flags_s;

    typedef struct packed {
        logic        master;
        done_flags_s flags;
    } irq_state_s;

    typedef struct packed {
        logic        valid;
        logic [15:0] opcode;
    } cmd_done_s;
endpackage : flash_irq_pkg

// >>> src/flash_irq_sync.sv
// two-flop synchroniser for pin-level inputs
`timescale 1ns/100ps
`default_nettype none
module flash_irq_sync (
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic din,
    output logic      dout
);
    logic meta_q;

    // first stage feeds only the second stage
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta_q <= 1'b0;
            dout   <= 1'b0;
        end else begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end
endmodule : flash_irq_sync
`default_nettype wire

// >>> src/flash_interrupt_status.sv
// interrupt status register with master flag and interrupt pin
`timescale 1ns/100ps
`default_nettype none
`include "flash_irq_defs.svh"
module flash_interrupt_status
    import flash_irq_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        warm_reset_n,
    input  wire logic        hot_reset,
    input  wire logic        boot_load_done,
    input  wire logic        buffer_load_done,
    input  wire cmd_done_s   cmd_done,
    input  wire logic        irq_pin_polarity,
    input  wire logic        reg_cs,
    input  wire logic        reg_we,
    input  wire logic [15:0] reg_addr,
    input  wire logic [15:0] reg_wdata,
    output logic      [15:0] reg_rdata,
    output logic             irq_pin
);
    // register state apart from the two synchronisers: one struct, one comb fill, one flop
    typedef struct packed {
        logic        rst_meta;
        logic        rst_sync;
        logic        warm_prev;
        irq_state_s  st;
        logic        pin;
        logic [15:0] rdata;
    } state_s;

    state_s s_q;
    state_s s_d;
    logic   warm_req_raw;
    logic   warm_req_sync;
    logic   pol_sync;
    logic   rstn_int;

    // warm pin is synchronised as an active-high request, so the
    // synchroniser's reset value of zero means no warm reset pending
    assign warm_req_raw = !warm_reset_n;

    // pins from outside the clock domain pass two flops
    flash_irq_sync u_sync_warm (
        .clk  (clk),
        .rstn (rstn_int),
        .din  (warm_req_raw),
        .dout (warm_req_sync)
    );
    flash_irq_sync u_sync_pol (
        .clk  (clk),
        .rstn (rstn_int),
        .din  (irq_pin_polarity),
        .dout (pol_sync)
    );

    // classify a finished command by opcode
    function automatic event_class_e classify(input logic [15:0] op);
        event_class_e c;
        c = EV_NONE;
        case (op)
            `CMD_LOAD_A, `CMD_LOAD_B: c = EV_LOAD;
            `CMD_PROG_A, `CMD_PROG_B, `CMD_PROG_C: c = EV_PROG;
            `CMD_ERASE_A, `CMD_ERASE_B, `CMD_ERASE_C: c = EV_ERASE;
            `CMD_RST_A, `CMD_RST_B, `CMD_RST_C: c = EV_RESET;
            `CMD_UNLOCK, `CMD_LOCK, `CMD_LOCKTIGHT: c = EV_MASTER;
            `CMD_ERASE_VERIFY, `CMD_OTP_ACCESS: c = EV_MASTER;
            default: c = EV_NONE;
        endcase
        return c;
    endfunction : classify

    // pack flag state into the 16-bit register image
    function automatic logic [15:0] image(input irq_state_s st);
        logic [15:0] v;
        v = `IRQ_ZERO;
        v[`IRQ_BIT_MASTER] = st.master;
        v[`IRQ_BIT_LOAD]   = st.flags.load_done_flag;
        v[`IRQ_BIT_PROG]   = st.flags.program_done_flag;
        v[`IRQ_BIT_ERASE]  = st.flags.erase_done_flag;
        v[`IRQ_BIT_RESET]  = st.flags.reset_done_flag;
        return v;
    endfunction : image

    assign rstn_int = s_q.rst_sync;

    event_class_e cls;
    logic         wr_hit;
    logic         warm_rel;
    logic         warm_enter;
    logic         set_load;
    logic         set_prog;
    logic         set_erase;
    logic         set_rst;
    logic         set_mst;

    // event decode: sets win over a same-cycle zero-write clear, but warm or hot reset wins over sets
    always_comb begin
        cls        = cmd_done.valid ? classify(cmd_done.opcode) : EV_NONE;
        wr_hit     = reg_cs && reg_we && (reg_addr == `IRQ_REG_ADDR);
        warm_rel   = !warm_req_sync && s_q.warm_prev;
        warm_enter = warm_req_sync || hot_reset;
        set_load   = (cls == EV_LOAD) || boot_load_done;
        set_prog   = (cls == EV_PROG);
        set_erase  = (cls == EV_ERASE);
        set_rst    = (cls == EV_RESET) || warm_rel;
        set_mst    = set_load || set_prog || set_erase || set_rst
                   || (cls == EV_MASTER) || buffer_load_done;
    end

    // next state
    always_comb begin
        s_d           = s_q;
        s_d.rst_meta  = 1'b1;
        s_d.rst_sync  = s_q.rst_meta;
        s_d.warm_prev = warm_req_sync;
        if (!s_q.rst_sync) begin
            // cold values held until the reset release has passed both
            // flops, so no flag can land while release is still settling
            s_d.st.master                  = 1'b1;
            s_d.st.flags.load_done_flag    = 1'b1;
            s_d.st.flags.program_done_flag = 1'b0;
            s_d.st.flags.erase_done_flag   = 1'b0;
            s_d.st.flags.reset_done_flag   = 1'b0;
        end else if (warm_enter) begin
            // warm/hot: master and reset flag set, rest cleared
            s_d.st.master                  = 1'b1;
            s_d.st.flags.load_done_flag    = 1'b0;
            s_d.st.flags.program_done_flag = 1'b0;
            s_d.st.flags.erase_done_flag   = 1'b0;
            s_d.st.flags.reset_done_flag   = 1'b1;
        end else begin
            // zero write clears, a one leaves the bit alone
            if (wr_hit) begin
                if (!reg_wdata[`IRQ_BIT_MASTER])
                    s_d.st.master = 1'b0;
                if (!reg_wdata[`IRQ_BIT_LOAD])
                    s_d.st.flags.load_done_flag = 1'b0;
                if (!reg_wdata[`IRQ_BIT_PROG])
                    s_d.st.flags.program_done_flag = 1'b0;
                if (!reg_wdata[`IRQ_BIT_ERASE])
                    s_d.st.flags.erase_done_flag = 1'b0;
                if (!reg_wdata[`IRQ_BIT_RESET])
                    s_d.st.flags.reset_done_flag = 1'b0;
            end
            if (set_load)  s_d.st.flags.load_done_flag    = 1'b1;
            if (set_prog)  s_d.st.flags.program_done_flag = 1'b1;
            if (set_erase) s_d.st.flags.erase_done_flag   = 1'b1;
            if (set_rst)   s_d.st.flags.reset_done_flag   = 1'b1;
            if (set_mst)   s_d.st.master                  = 1'b1;
        end
        // pin: active level is polarity, idle level is its inverse
        s_d.pin   = s_d.st.master ? pol_sync : !pol_sync;
        s_d.rdata = image(s_d.st); // registered read data
    end

    // reset releases through two flops; cold value is 8080h
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_q.rst_meta                     <= 1'b0;
            s_q.rst_sync                     <= 1'b0;
            s_q.warm_prev                    <= 1'b0;
            s_q.st.master                    <= 1'b1;
            s_q.st.flags.load_done_flag      <= 1'b1;
            s_q.st.flags.program_done_flag   <= 1'b0;
            s_q.st.flags.erase_done_flag     <= 1'b0;
            s_q.st.flags.reset_done_flag     <= 1'b0;
            s_q.pin                          <= 1'b0;
            s_q.rdata                        <= `IRQ_COLD_VALUE;
        end else begin
            s_q <= s_d;
        end
    end

    assign reg_rdata = s_q.rdata;
    assign irq_pin   = s_q.pin;

    // checks: all are masked while the internal reset copy is low,
    // since the state is held at its cold values until then

    // read image and reset values
    a_rdata_image: assert property (
        @(posedge clk) disable iff (!rstn_int)
        reg_rdata == image(s_q.st))
        else $error("read data does not match flag state");
    a_reserved_zero: assert property (
        @(posedge clk) disable iff (!rstn_int)
        reg_rdata[14:8] == 7'h00 && reg_rdata[3:0] == 4'h0)
        else $error("reserved bits not zero");
    a_cold_value: assert property (
        @(posedge clk) disable iff (!rstn_int)
        $rose(rstn_int) |-> reg_rdata == `IRQ_COLD_VALUE)
        else $error("cold reset value wrong");
    a_warm_value: assert property (
        @(posedge clk) disable iff (!rstn_int)
        warm_enter |=> reg_rdata == `IRQ_WARM_VALUE)
        else $error("warm reset value wrong");

    // each completion flag sets on its own events
    a_load_sets: assert property (
        @(posedge clk) disable iff (!rstn_int)
        set_load && !warm_enter |=> s_q.st.flags.load_done_flag)
        else $error("load flag not set");
    a_prog_sets: assert property (
        @(posedge clk) disable iff (!rstn_int)
        set_prog && !warm_enter |=> s_q.st.flags.program_done_flag)
        else $error("program flag not set");
    a_erase_sets: assert property (
        @(posedge clk) disable iff (!rstn_int)
        set_erase && !warm_enter |=> s_q.st.flags.erase_done_flag)
        else $error("erase flag not set");
    a_rst_sets: assert property (
        @(posedge clk) disable iff (!rstn_int)
        set_rst |=> s_q.st.flags.reset_done_flag)
        else $error("reset flag not set");

    // master follows the flags, the commands without a flag and buffer loads
    a_master_follows: assert property (
        @(posedge clk) disable iff (!rstn_int)
        $rose(s_q.st.flags.erase_done_flag) |-> s_q.st.master)
        else $error("master missed a flag");
    a_master_flags: assert property (
        @(posedge clk) disable iff (!rstn_int)
        ($rose(s_q.st.flags.load_done_flag) ||
         $rose(s_q.st.flags.program_done_flag) ||
         $rose(s_q.st.flags.reset_done_flag)) |-> s_q.st.master)
        else $error("master missed a flag");
    a_master_cmd: assert property (
        @(posedge clk) disable iff (!rstn_int)
        cls == EV_MASTER |=> s_q.st.master)
        else $error("master missed a command");
    a_master_buffer: assert property (
        @(posedge clk) disable iff (!rstn_int)
        buffer_load_done |=> s_q.st.master)
        else $error("master missed a buffer load");

    // clears by a zero write and by warm or hot reset
    a_master_clear: assert property (
        @(posedge clk) disable iff (!rstn_int)
        wr_hit && !reg_wdata[`IRQ_BIT_MASTER] && !set_mst && !warm_enter
        |=> !s_q.st.master)
        else $error("master not cleared");
    a_load_clear: assert property (
        @(posedge clk) disable iff (!rstn_int)
        wr_hit && !reg_wdata[`IRQ_BIT_LOAD] && !set_load && !warm_enter
        |=> !s_q.st.flags.load_done_flag)
        else $error("load flag not cleared");
    a_rst_clear: assert property (
        @(posedge clk) disable iff (!rstn_int)
        wr_hit && !reg_wdata[`IRQ_BIT_RESET] && !set_rst && !warm_enter
        |=> !s_q.st.flags.reset_done_flag)
        else $error("reset flag not cleared");
    a_warm_clears: assert property (
        @(posedge clk) disable iff (!rstn_int)
        warm_enter |=> !s_q.st.flags.load_done_flag &&
        !s_q.st.flags.program_done_flag && !s_q.st.flags.erase_done_flag)
        else $error("warm reset left a flag set");
    a_rst_survives: assert property (
        @(posedge clk) disable iff (!rstn_int)
        warm_enter |=> s_q.st.flags.reset_done_flag)
        else $error("warm reset cleared reset flag");

    // pin is registered from the next-state master, so it matches the current master and last cycle's polarity
    a_pin_level: assert property (
        @(posedge clk) disable iff (!rstn_int)
        irq_pin == ($past(s_d.st.master) ? $past(pol_sync)
                                         : !$past(pol_sync)))
        else $error("pin level wrong");

    // only hardware events set flags; writes of one do nothing
    a_one_no_set: assert property (
        @(posedge clk) disable iff (!rstn_int)
        wr_hit && !s_q.st.flags.program_done_flag && !set_prog
        |=> !s_q.st.flags.program_done_flag)
        else $error("write of one set a flag");
    a_no_stray_load: assert property (
        @(posedge clk) disable iff (!rstn_int)
        !set_load && !s_q.st.flags.load_done_flag |=>
        !s_q.st.flags.load_done_flag)
        else $error("load flag set without event");
    a_no_stray_erase: assert property (
        @(posedge clk) disable iff (!rstn_int)
        !set_erase && !s_q.st.flags.erase_done_flag |=>
        !s_q.st.flags.erase_done_flag)
        else $error("erase flag set without event");
    a_no_stray_master: assert property (
        @(posedge clk) disable iff (!rstn_int)
        !set_mst && !warm_enter && !s_q.st.master |=> !s_q.st.master)
        else $error("master set without event");
    a_no_stray_rst: assert property (
        @(posedge clk) disable iff (!rstn_int)
        !set_rst && !warm_enter && !s_q.st.flags.reset_done_flag |=>
        !s_q.st.flags.reset_done_flag)
        else $error("reset flag set without event");

    // main scenarios
    c_prog_done: cover property (@(posedge clk) set_prog);
    c_buffer_load: cover property (@(posedge clk) buffer_load_done);
    c_warm: cover property (@(posedge clk) warm_rel);
    c_clear_master: cover property (@(posedge clk) $fell(s_q.st.master));
    c_set_and_clear: cover property (@(posedge clk) wr_hit && set_mst);
endmodule : flash_interrupt_status
`default_nettype wire

// >>> verification/host_model.sv
// host side: drives register writes onto the memory bus
`timescale 1ns/100ps
`default_nettype none
module host_model (
    input  wire logic        clk,
    input  wire logic        go,
    input  wire logic [15:0] addr,
    input  wire logic [15:0] wdata,
    output logic             reg_cs,
    output logic             reg_we,
    output logic      [15:0] reg_addr,
    output logic      [15:0] reg_wdata
);
    logic [15:0] last_a_q;
    logic [15:0] last_d_q;
    // a zero bit in wdata is how the host clears a flag
    assign reg_cs    = go;
    assign reg_we    = go;
    // released bus shows the inverse of the last value, not a stale copy
    assign reg_addr  = go ? addr : ~last_a_q;
    assign reg_wdata = go ? wdata : ~last_d_q;
    always_ff @(posedge clk) begin
        if (go) begin
            last_a_q <= addr;
            last_d_q <= wdata;
        end
    end
endmodule : host_model
`default_nettype wire

// >>> verification/tb_flash_interrupt_status.sv
// self-checking bench for the interrupt status register
`timescale 1ns/100ps
`default_nettype none
module tb_flash_interrupt_status;
    import flash_irq_pkg::*;
    logic        clk, rstn, warm_n, hot, bl, bf, pol, go, cs, we, irq;
    cmd_done_s   cmd;
    logic [15:0] h_a, h_d, addr, wdata, rdata, e;
    logic [31:0] r;
    int          fails, num_checks, i;
    logic [15:0] ops [16] = '{16'h0000, 16'h0013, 16'h0080, 16'h001a,
        16'h001b, 16'h0094, 16'h0095, 16'h0030, 16'h00b0, 16'h00f0,
        16'h00f3, 16'h0023, 16'h002a, 16'h002c, 16'h0071, 16'h0065};

    flash_interrupt_status uut (.clk(clk), .rstn(rstn),
        .warm_reset_n(warm_n), .hot_reset(hot), .boot_load_done(bl),
        .buffer_load_done(bf), .cmd_done(cmd), .irq_pin_polarity(pol),
        .reg_cs(cs), .reg_we(we), .reg_addr(addr), .reg_wdata(wdata),
        .reg_rdata(rdata), .irq_pin(irq));
    host_model host (.clk(clk), .go(go), .addr(h_a), .wdata(h_d),
        .reg_cs(cs), .reg_we(we), .reg_addr(addr), .reg_wdata(wdata));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // events set bits; listed opcodes only
    function automatic logic [15:0] evm(input logic [15:0] op);
        for (int k = 0; k < 16; k++) begin
            if (ops[k] === op) begin
                return k < 2 ? 16'h8080 : k < 5 ? 16'h8040 :
                    k < 8 ? 16'h8020 : k < 11 ? 16'h8010 : 16'h8000;
            end
        end
        return 16'h0000;
    endfunction : evm
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic chk(input logic [15:0] seen, input logic [15:0] want);
        num_checks++;
        if (seen !== want) begin
            fails++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, want);
        end
    endtask : chk
    task automatic look();
        @(negedge clk);
        chk(rdata, e);
        chk({15'h0000, irq}, {15'h0000, e[15] ? pol : ~pol});
    endtask : look
    // one bus/event cycle, then the model update and a compare
    task automatic step(input logic [15:0] op, input logic v, b0, b1, w,
                        input logic [15:0] a, d);
        @(posedge clk);
        cmd <= '{valid: v, opcode: op};
        bl <= b0;
        bf <= b1;
        go <= w;
        h_a <= a;
        h_d <= d;
        if (w && a == 16'hf241) e = e & (d | 16'h7f0f);
        if (v) e = e | evm(op);
        if (b0) e = e | 16'h8080;
        if (b1) e = e | 16'h8000;
        @(posedge clk);
        cmd.valid <= 1'b0;
        bl <= 1'b0;
        bf <= 1'b0;
        go <= 1'b0;
        look();
    endtask : step
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : end_sim

    initial begin
        repeat (6000) @(posedge clk);
        fails++;
        end_sim();
    end
    initial begin
        {rstn, hot, bl, bf, go} = 5'b00000;
        {warm_n, pol} = 2'b11;
        cmd = '0;
        h_a = 16'h0000;
        h_d = 16'h0000;
        r = 32'hcc50152d;
        e = 16'h8080;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        repeat (6) @(posedge clk);
        look();
        step(16'h0000, 1'b0, 1'b0, 1'b0, 1'b1, 16'hf241, 16'hffff);
        $display("test cold defaults done");
        for (i = 0; i < 18; i++) begin
            step(16'h0000, 1'b0, 1'b0, 1'b0, 1'b1, 16'hf241, 16'h0000);
            step(ops[i % 16], i < 16, i == 16, i == 17, 1'b0, 16'h0, 16'h0);
        end
        $display("test event table done");
        // polarity flip goes through a synchroniser, so allow settling
        @(posedge clk);
        pol <= 1'b0;
        repeat (4) @(posedge clk);
        look();
        step(16'h0000, 1'b0, 1'b0, 1'b0, 1'b1, 16'hf241, 16'h0000);
        @(posedge clk);
        pol <= 1'b1;
        repeat (4) @(posedge clk);
        look();
        $display("test polarity done");
        step(16'h0080, 1'b1, 1'b0, 1'b0, 1'b0, 16'h0, 16'h0);
        @(posedge clk);
        warm_n <= 1'b0;
        repeat (5) @(posedge clk);
        e = 16'h8010;
        look();
        @(posedge clk);
        warm_n <= 1'b1;
        repeat (5) @(posedge clk);
        look();
        step(16'h0000, 1'b0, 1'b0, 1'b0, 1'b1, 16'hf241, 16'h0010);
        step(16'h0094, 1'b1, 1'b0, 1'b0, 1'b0, 16'h0, 16'h0);
        @(posedge clk);
        hot <= 1'b1;
        repeat (3) @(posedge clk);
        e = 16'h8010;
        look();
        @(posedge clk);
        hot <= 1'b0;
        $display("test warm and hot reset done");
        for (i = 0; i < 400; i++) begin
            r = lfsr(r);
            step(ops[r[3:0]], r[4], r[5] & r[6], r[7] & r[8], r[9],
                 r[10] ? 16'hf241 : r[31:16], r[31:16]);
        end
        $display("test random traffic done");
        end_sim();
    end
endmodule : tb_flash_interrupt_status
`default_nettype wire
